// ### rtl/bbc_consts.svh
// constants of the bit stream buffer conformance checker
// assumes a single 25 MHz system clock; included by bare name
`ifndef BBC_CONSTS_SVH
`define BBC_CONSTS_SVH
// clock rate; rates in bits per second are added once per cycle
// to levels held scaled by this figure
`define BBC_CLK_PERIOD_NS 40
`define BBC_FREQ_HZ 64'd25000000
// most leaky bucket triples held on chip
`define BBC_NB 4
`define BBC_NB_W 3
// reset values
`define BBC_LEVEL_RST 64'h0
`define BBC_WORD_RST 32'h0
// number of divide steps in the calculation sequence
`define BBC_STEPS 3'h5
`endif

// ### rtl/bbc_pkg.sv
// types of the bit stream buffer conformance checker
// assumes bbc_consts.svh is on the include path
`include "bbc_consts.svh"
`default_nettype none
package bbc_pkg;
   // one declared leaky bucket, as carried in the stream header
   typedef struct packed {
      logic [31:0] rate;
      logic [31:0] size;
      logic [31:0] full;
   } bbc_triple_type;
   // one coded picture offered by the source
   typedef struct packed {
      logic [31:0] bits;
      logic [31:0] pres;
      logic is_b;
   } bbc_pic_type;
   // sticky status
   typedef struct packed {
      logic hdr_order;
      logic hdr_count;
      logic buf_over;
      logic buf_under;
      logic [`BBC_NB-1:0] bkt_over;
   } bbc_flags_type;
   // derived figures
   typedef struct packed {
      logic [31:0] bmin;
      logic [31:0] fmin;
      logic [31:0] rmin;
      logic [31:0] fminb;
      logic [31:0] delay;
      logic guaranteed;
      logic decodable;
   } bbc_result_type;
   typedef enum logic [1:0] {
      C_IDLE = 2'b00,
      C_LOAD = 2'b01,
      C_WAIT = 2'b10
   } bbc_cstate_type;
endpackage
`default_nettype wire

// ### rtl/bbc_divider.sv
// restoring unsigned divider, one quotient bit per cycle
// assumes start is a one-cycle pulse given while idle
`include "bbc_consts.svh"
`default_nettype none
module bbc_divider (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic start,
   input wire logic [63:0] num,
   input wire logic [63:0] den,
   output logic done,
   output logic [63:0] quot
);
   logic [63:0] rem;
   logic [63:0] dv;
   logic [6:0] cnt;
   logic busy;
   // trial subtraction on the shifted remainder
   wire [64:0] shifted = {rem, quot[63]};
   wire [64:0] trial = shifted - {1'b0, dv};
   wire fits = !trial[64];

   // a zero divisor yields all ones, which later saturates the result
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         rem <= `BBC_LEVEL_RST;
         dv <= `BBC_LEVEL_RST;
         quot <= `BBC_LEVEL_RST;
         cnt <= 7'h0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            rem <= 64'h0;
            dv <= den;
            quot <= num;
            cnt <= 7'h40;
            busy <= 1'b1;
         end else if (busy) begin
            rem <= fits ? trial[63:0] : shifted[63:0];
            quot <= {quot[62:0], fits};
            cnt <= cnt - 7'h1;
            if (cnt == 7'h1) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### rtl/bbc_checker.sv
// decoder input buffer model and leaky bucket containment checker
// assumes header bytes, pictures and controls come from sys_clk logic;
// chan_active is a pin and is synchronised before use
`include "bbc_consts.svh"
`default_nettype none
module bbc_checker
   import bbc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic hdr_valid,
   input wire logic [7:0] hdr_byte,
   input wire logic chan_active,
   input wire logic [31:0] peak_rate,
   input wire logic [31:0] buf_size,
   input wire logic [31:0] init_full,
   input wire logic has_b,
   input wire logic [31:0] first_gap,
   input wire logic pic_valid,
   input wire bbc_pic_type pic,
   output logic pic_ready,
   input wire logic calc_start,
   output logic decode_pulse,
   output logic [63:0] fullness,
   output bbc_flags_type flags,
   output logic hdr_done,
   output bbc_result_type result,
   output logic calc_done
);
   localparam int NB = `BBC_NB;

   // header parser
   bbc_triple_type trip [NB];
   logic [23:0] word_sh;
   logic [1:0] byte_cnt;
   logic got_n;
   logic [1:0] fld;
   logic [`BBC_NB_W-1:0] tidx;
   logic [`BBC_NB_W-1:0] nb;
   wire [31:0] full_word = {word_sh, hdr_byte};
   wire word_done = hdr_valid && !hdr_done && (byte_cnt == 2'h3);
   wire [1:0] prev_i = tidx[1:0] - 2'h1;
   wire [31:0] prev_f = (fld == 2'h0) ? trip[prev_i].rate :
                        (fld == 2'h1) ? trip[prev_i].size : trip[prev_i].full;
   wire bad_order = (tidx != '0) && ((fld == 2'h0) ? (full_word <= prev_f) :
                    (full_word >= prev_f));
   wire n_zero = (full_word == 32'h0);
   wire n_big = (full_word > 32'(NB));

   // bytes assemble most significant first into words
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         word_sh <= 24'h0;
         byte_cnt <= 2'h0;
         got_n <= 1'b0;
         fld <= 2'h0;
         tidx <= '0;
         nb <= '0;
         hdr_done <= 1'b0;
      end else if (hdr_valid && !hdr_done) begin
         word_sh <= full_word[23:0];
         byte_cnt <= byte_cnt + 2'h1;
         if (word_done && !got_n) begin
            got_n <= 1'b1;
            nb <= n_big ? `BBC_NB_W'(NB) : full_word[`BBC_NB_W-1:0];
            hdr_done <= n_zero;
         end else if (word_done) begin
            fld <= (fld == 2'h2) ? 2'h0 : fld + 2'h1;
            if (fld == 2'h2) begin
               tidx <= tidx + 1'b1;
               hdr_done <= (tidx + 1'b1 == nb);
            end
         end
      end
   end

   // triple storage, one field per finished word
   always_ff @(posedge sys_clk) begin
      if (word_done && got_n) begin
         unique case (fld)
            2'h0: trip[tidx[1:0]].rate <= full_word;
            2'h1: trip[tidx[1:0]].size <= full_word;
            default: trip[tidx[1:0]].full <= full_word;
         endcase
      end
   end

   // channel activity pin, two flops before use
   logic ch_s1;
   logic ch_s2;
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         ch_s1 <= 1'b0;
         ch_s2 <= 1'b0;
      end else begin
         ch_s1 <= chan_active;
         ch_s2 <= ch_s1;
      end
   end

   // buffer model; all bit levels carry a factor of the clock rate so a
   // rate in bits per second is added once per cycle without a divide
   logic started;
   logic t0_seen;
   logic [31:0] t_cnt;
   logic [31:0] t0_time;
   logic [31:0] t_last;
   logic [63:0] s_cum;
   logic pend;
   logic [31:0] pend_bits;
   logic [31:0] pend_dec;
   logic first_pic;
   logic acc_any;
   logic [31:0] dec0;
   logic [31:0] last_anchor;
   wire [63:0] rate_in = ch_s2 ? 64'(peak_rate) : 64'h0;
   wire [63:0] s_next = s_cum + rate_in;
   wire [63:0] f_sc = 64'(init_full) * `BBC_FREQ_HZ;
   wire [63:0] cap_sc = 64'(buf_size) * `BBC_FREQ_HZ;
   wire [63:0] bits_sc = 64'(pend_bits) * `BBC_FREQ_HZ;
   wire t0_hit = !t0_seen && (started || ch_s2) && (s_next >= f_sc);
   wire due_first = pend && first_pic && (t0_seen || t0_hit);
   wire due_next = pend && !first_pic && ((t_cnt - t0_time) >= (pend_dec - dec0));
   wire dec_now = due_first || due_next;
   wire accept = pic_valid && pic_ready;
   wire next_pend = (pend && !dec_now) || accept;
   // decode offset: zero for B pictures or B-free sequences, else anchor gap
   wire [31:0] m_off = (!has_b || pic.is_b) ? 32'h0 :
                       (!acc_any ? first_gap : pic.pres - last_anchor);
   wire [31:0] dec_i = pic.pres - m_off;
   wire [63:0] fill = fullness + rate_in;
   wire under = dec_now && (bits_sc > fill);
   wire [63:0] after_dec = dec_now ? (under ? 64'h0 : fill - bits_sc) : fill;
   wire over = after_dec > cap_sc;

   // time base, first decode instant and picture hand-off
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         started <= 1'b0;
         t0_seen <= 1'b0;
         t_cnt <= `BBC_WORD_RST;
         t0_time <= `BBC_WORD_RST;
         t_last <= `BBC_WORD_RST;
         s_cum <= `BBC_LEVEL_RST;
         fullness <= `BBC_LEVEL_RST;
         pend <= 1'b0;
         pic_ready <= 1'b0;
         decode_pulse <= 1'b0;
      end else begin
         started <= started || ch_s2;
         t_cnt <= (started || ch_s2) ? t_cnt + 32'h1 : t_cnt;
         s_cum <= s_next;
         if (t0_hit) begin
            t0_seen <= 1'b1;
            t0_time <= t_cnt;
         end
         if (dec_now) begin
            t_last <= t_cnt;
         end
         // full buffer holds at capacity; the excess is reported, not kept
         fullness <= over ? cap_sc : after_dec;
         pend <= next_pend;
         pic_ready <= !next_pend;
         decode_pulse <= dec_now;
      end
   end

   // picture bookkeeping; no reset needed for data beside the flags
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         first_pic <= 1'b1;
         acc_any <= 1'b0;
      end else begin
         if (dec_now) begin
            first_pic <= 1'b0;
         end
         if (accept) begin
            acc_any <= 1'b1;
         end
      end
      if (accept) begin
         pend_bits <= pic.bits;
         pend_dec <= dec_i;
         if (!acc_any) begin
            dec0 <= dec_i;
         end
         if (!pic.is_b) begin
            last_anchor <= pic.pres;
         end
      end
   end

   // one leaky bucket per declared triple
   logic [NB-1:0] bkt_ovf;
   genvar g;
   generate
      for (g = 0; g < NB; g++) begin : gen_bkt
         logic [63:0] lvl;
         logic run;
         wire [63:0] bsc = 64'(trip[g].size) * `BBC_FREQ_HZ;
         wire [63:0] init_lvl = (trip[g].size >= trip[g].full) ?
                                64'(trip[g].size - trip[g].full) * `BBC_FREQ_HZ : 64'h0;
         wire [63:0] ins = dec_now ? lvl + bits_sc : lvl;
         wire [63:0] rt = 64'(trip[g].rate);
         assign bkt_ovf[g] = dec_now && (`BBC_NB_W'(g) < nb) && (ins > bsc);
         always_ff @(posedge sys_clk) begin
            if (!rstn) begin
               lvl <= `BBC_LEVEL_RST;
               run <= 1'b0;
            end else if (!run && !dec_now) begin
               lvl <= init_lvl;
            end else begin
               run <= 1'b1;
               lvl <= (ins > rt) ? ins - rt : 64'h0;
            end
         end
      end
   endgenerate

   // error flags never clear except by reset
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         flags <= '0;
      end else begin
         flags.hdr_order <= flags.hdr_order || (word_done && got_n && bad_order);
         flags.hdr_count <= flags.hdr_count || (word_done && !got_n && (n_zero || n_big));
         flags.buf_over <= flags.buf_over || over;
         flags.buf_under <= flags.buf_under || under;
         flags.bkt_over <= flags.bkt_over | bkt_ovf;
      end
   end

   // neighbour search; rates ascend and sizes descend, so counts give the index
   logic [`BBC_NB_W-1:0] cnt_r;
   logic [`BBC_NB_W-1:0] cnt_b;
   always_comb begin
      cnt_r = '0;
      cnt_b = '0;
      for (int k = 0; k < NB; k++) begin
         if ((`BBC_NB_W'(k) < nb) && (trip[k].rate <= peak_rate)) begin
            cnt_r = cnt_r + 1'b1;
         end
         if ((`BBC_NB_W'(k) < nb) && (trip[k].size >= buf_size)) begin
            cnt_b = cnt_b + 1'b1;
         end
      end
   end
   wire [1:0] last = 2'(nb - 1'b1);
   wire [1:0] nr = 2'(cnt_r - 1'b1);
   wire [1:0] nbi = 2'(cnt_b - 1'b1);
   wire lo_r = peak_rate <= trip[0].rate;
   wire hi_r = peak_rate >= trip[last].rate;
   wire lo_b = buf_size >= trip[0].size;
   wire hi_b = buf_size <= trip[last].size;
   wire [31:0] dur = t_last - t0_time;
   bbc_triple_type ra;
   bbc_triple_type rb;
   bbc_triple_type sa;
   bbc_triple_type sb;
   assign ra = trip[nr];
   assign rb = trip[2'(nr + 2'h1)];
   assign sa = trip[nbi];
   assign sb = trip[2'(nbi + 2'h1)];

   // per step operands: result = base plus or minus num / den
   bbc_cstate_type cst;
   logic [2:0] step;
   logic [31:0] base;
   logic [63:0] num;
   logic [63:0] den;
   logic sub;
   always_comb begin
      base = 32'h0;
      num = 64'h0;
      den = 64'h1;
      sub = 1'b0;
      unique case (step)
         3'h0: begin
            if (hi_r) begin
               base = trip[last].size;
            end else if (lo_r) begin
               base = trip[0].size;
               num = 64'(trip[0].rate - peak_rate) * 64'(dur);
               den = `BBC_FREQ_HZ;
            end else begin
               base = rb.size;
               num = 64'(ra.size - rb.size) * 64'(rb.rate - peak_rate);
               den = 64'(rb.rate - ra.rate);
            end
         end
         3'h1: begin
            if (hi_r || lo_r) begin
               base = hi_r ? trip[last].full : trip[0].full;
            end else begin
               base = rb.full;
               num = 64'(ra.full - rb.full) * 64'(rb.rate - peak_rate);
               den = 64'(rb.rate - ra.rate);
            end
         end
         3'h2: begin
            sub = 1'b1;
            if (lo_b) begin
               base = trip[0].rate;
               num = (dur == 32'h0) ? 64'h0 : 64'(buf_size - trip[0].size) * `BBC_FREQ_HZ;
               den = (dur == 32'h0) ? 64'h1 : 64'(dur);
            end else if (hi_b) begin
               base = trip[last].rate;
            end else begin
               base = sb.rate;
               num = 64'(sb.rate - sa.rate) * 64'(buf_size - sb.size);
               den = 64'(sa.size - sb.size);
            end
         end
         3'h3: begin
            if (lo_b || hi_b) begin
               base = lo_b ? trip[0].full : trip[last].full;
            end else begin
               base = sb.full;
               num = 64'(sa.full - sb.full) * 64'(buf_size - sb.size);
               den = 64'(sa.size - sb.size);
            end
         end
         default: begin
            num = 64'(result.fmin) * `BBC_FREQ_HZ;
            den = 64'(peak_rate);
         end
      endcase
   end

   logic div_go;
   logic div_done;
   logic [63:0] quot;
   bbc_divider u_div (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .start(div_go),
      .num(num),
      .den(den),
      .done(div_done),
      .quot(quot)
   );
   // saturate rather than wrap when a quotient overshoots the base
   wire [31:0] q_lo = (quot[63:32] != 32'h0) ? 32'hffffffff : quot[31:0];
   wire [32:0] sum_w = {1'b0, base} + {1'b0, q_lo};
   wire [31:0] val = sub ? ((quot > 64'(base)) ? 32'h0 : base - quot[31:0]) :
                     (sum_w[32] ? 32'hffffffff : sum_w[31:0]);
   wire hdr_ok = hdr_done && !flags.hdr_order && !flags.hdr_count;
   wire fit = (buf_size >= result.bmin) && (init_full >= result.fmin);

   // calculation sequence, one divide per derived figure
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         cst <= C_IDLE;
         step <= 3'h0;
         div_go <= 1'b0;
         calc_done <= 1'b0;
         result <= '0;
      end else begin
         div_go <= 1'b0;
         calc_done <= 1'b0;
         unique case (cst)
            C_IDLE: begin
               if (calc_start && hdr_ok) begin
                  step <= 3'h0;
                  cst <= C_LOAD;
               end
            end
            C_LOAD: begin
               div_go <= 1'b1;
               cst <= C_WAIT;
            end
            C_WAIT: begin
               if (div_done) begin
                  unique case (step)
                     3'h0: result.bmin <= val;
                     3'h1: result.fmin <= val;
                     3'h2: result.rmin <= val;
                     3'h3: result.fminb <= val;
                     default: result.delay <= quot[31:0];
                  endcase
                  step <= step + 3'h1;
                  cst <= (step == `BBC_STEPS - 3'h1) ? C_IDLE : C_LOAD;
                  if (step == `BBC_STEPS - 3'h1) begin
                     result.guaranteed <= !hi_b || (buf_size == trip[last].size);
                     result.decodable <= fit && (peak_rate != 32'h0);
                     calc_done <= 1'b1;
                  end
               end
            end
            default: cst <= C_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ### test/bbc_checker_props.sv
// assertions on the ports of the buffer conformance checker
// assumes one sys_clk domain with synchronous active-low rstn
`include "bbc_consts.svh"
`default_nettype none
module bbc_checker_props
   import bbc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic hdr_valid,
   input wire logic [7:0] hdr_byte,
   input wire logic chan_active,
   input wire logic [31:0] peak_rate,
   input wire logic [31:0] buf_size,
   input wire logic [31:0] init_full,
   input wire logic has_b,
   input wire logic [31:0] first_gap,
   input wire logic pic_valid,
   input wire bbc_pic_type pic,
   input wire logic pic_ready,
   input wire logic calc_start,
   input wire logic decode_pulse,
   input wire logic [63:0] fullness,
   input wire bbc_flags_type flags,
   input wire logic hdr_done,
   input wire bbc_result_type result,
   input wire logic calc_done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic busy;
   wire calc_acc = calc_start && hdr_done && !flags.hdr_order && !flags.hdr_count && !busy;
   // shadow of the calculation busy state, so only honoured starts are timed
   always_ff @(posedge sys_clk) begin
      if (!rstn) busy <= 1'b0;
      else if (calc_acc) busy <= 1'b1;
      else if (calc_done) busy <= 1'b0;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   a_pulse_single: assert property (decode_pulse |=> !decode_pulse)
      else $error("decode pulse longer than one cycle");
   a_take_ready: assert property (pic_valid && pic_ready |=> !pic_ready)
      else $error("ready stayed high after a picture was taken");
   a_ready_back: assert property ($past(rstn, 2) && $rose(pic_ready) |-> decode_pulse)
      else $error("ready returned without a decode");
   a_flags_sticky: assert property ($past(rstn) |-> (flags & $past(flags)) == $past(flags))
      else $error("a status flag cleared without reset");
   a_hdr_hold: assert property (hdr_done |=> hdr_done)
      else $error("header done dropped");
   a_decodable_rule: assert property (calc_done |-> result.decodable ==
      (buf_size >= result.bmin && init_full >= result.fmin && peak_rate != 0))
      else $error("decodable verdict disagrees with minimum figures");
   a_cap_limit: assert property (fullness <= 64'(buf_size) * `BBC_FREQ_HZ)
      else $error("fullness above buffer capacity");
   a_idle_flat: assert property (!chan_active [*3] |=> fullness <= $past(fullness))
      else $error("fullness grew while channel idle");
   a_calc_bound: assert property (calc_acc |-> ##[300:400] calc_done)
      else $error("calculation did not finish in time");
   cover property (decode_pulse);
   cover property (calc_done && result.decodable);
   cover property ($rose(flags.buf_under));
endmodule
bind bbc_checker bbc_checker_props bbc_checker_props_inst (
   .sys_clk(sys_clk), .rstn(rstn), .hdr_valid(hdr_valid), .hdr_byte(hdr_byte),
   .chan_active(chan_active), .peak_rate(peak_rate), .buf_size(buf_size),
   .init_full(init_full), .has_b(has_b), .first_gap(first_gap), .pic_valid(pic_valid),
   .pic(pic), .pic_ready(pic_ready), .calc_start(calc_start),
   .decode_pulse(decode_pulse), .fullness(fullness), .flags(flags),
   .hdr_done(hdr_done), .result(result), .calc_done(calc_done)
);
`default_nettype wire

// ### test/bbc_source.sv
// bit stream source: header bytes, channel delivery and coded pictures
// assumes sys_clk of the checker; drives 1 ns after each rising edge
`default_nettype none
module bbc_source
   import bbc_pkg::*;
(
   input wire logic sys_clk,
   output logic hdr_valid,
   output logic [7:0] hdr_byte,
   output logic chan_active,
   output logic pic_valid,
   output bbc_pic_type pic,
   input wire logic pic_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      hdr_valid = 1'b0;
      hdr_byte = 8'h5a;
      chan_active = 1'b0;
      pic_valid = 1'b0;
      pic = '1;
   end
   // words go out back to back; idle byte lane is inverted so stale data never matches
   task automatic send_hdr(input logic [31:0] w[7], input int n);
      for (int i = 0; i < n; i++) begin
         for (int b = 3; b >= 0; b--) begin
            @(posedge sys_clk);
            #1;
            hdr_valid = 1'b1;
            hdr_byte = w[i][8 * b +: 8];
         end
      end
      @(posedge sys_clk);
      #1;
      hdr_valid = 1'b0;
      hdr_byte = ~hdr_byte;
   endtask
   // channel delivers only while active, at the peak rate set by the bench
   task automatic run_chan(input int k);
      @(posedge sys_clk);
      #1;
      chan_active = 1'b1;
      repeat (k) @(posedge sys_clk);
      #1;
      chan_active = 1'b0;
   endtask
   // picture held until the edge that samples ready high
   task automatic send_pic(input logic [31:0] bits, input logic [31:0] pres, input logic is_b);
      @(posedge sys_clk);
      #1;
      pic_valid = 1'b1;
      pic = '{bits, pres, is_b};
      // ready is settled here, so it is the value the next edge samples
      while (pic_ready !== 1'b1) begin
         @(posedge sys_clk);
         #1;
      end
      @(posedge sys_clk);
      #1;
      pic_valid = 1'b0;
      pic = ~pic;
   endtask
endmodule
`default_nettype wire

// ### test/bbc_checker_tb.sv
// self-checking bench for the buffer conformance checker
// assumes bbc_source drives the stream side; channel at 1 bit per cycle
`include "bbc_consts.svh"
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
`define WAITON(c, n) begin t = 0; while ((c) !== 1'b1 && t < n) begin step(); t++; end end
module bbc_checker_tb
   import bbc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, rstn, hdr_valid, chan_active, has_b, pic_valid, pic_ready, calc_start;
   logic decode_pulse, hdr_done, calc_done, seen;
   logic [7:0] hdr_byte;
   logic [31:0] peak_rate, buf_size, init_full, first_gap;
   logic [63:0] fullness;
   bbc_pic_type pic;
   bbc_flags_type flags;
   bbc_result_type result;
   int error_cnt, checked, cyc, k, d0, t, c1, r;
   logic [31:0] hw[7];
   logic [31:0] hb[7] = '{32'h2, 32'h01312d00, 32'h1f40, 32'hfa0, 32'h01c9c380, 32'hfa0, 32'h7d0};
   bbc_checker bbc_checker_inst (.sys_clk(sys_clk), .rstn(rstn), .hdr_valid(hdr_valid),
      .hdr_byte(hdr_byte), .chan_active(chan_active), .peak_rate(peak_rate),
      .buf_size(buf_size), .init_full(init_full), .has_b(has_b), .first_gap(first_gap),
      .pic_valid(pic_valid), .pic(pic), .pic_ready(pic_ready), .calc_start(calc_start),
      .decode_pulse(decode_pulse), .fullness(fullness), .flags(flags),
      .hdr_done(hdr_done), .result(result), .calc_done(calc_done));
   bbc_source bbc_source_inst (.sys_clk(sys_clk), .hdr_valid(hdr_valid),
      .hdr_byte(hdr_byte), .chan_active(chan_active), .pic_valid(pic_valid), .pic(pic),
      .pic_ready(pic_ready));
   // straight-line interpolation between two declared triples
   function automatic longint lin(input longint x, x1, x2, y1, y2);
      return y1 + (y2 - y1) * (x - x1) / (x2 - x1);
   endfunction
   task automatic step();
      @(posedge sys_clk);
      #1;
   endtask
   task automatic pulse_calc();
      calc_start = 1'b1;
      step();
      calc_start = 1'b0;
   endtask
   task automatic do_reset();
      rstn = 1'b0;
      repeat (20) step();
      rstn = 1'b1;
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // run limit well above the roughly 16k cycles the sequence needs
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         test_done();
      end
   end
   initial begin
      rstn = 1'b0;
      has_b = 1'b0;
      first_gap = 32'h0;
      calc_start = 1'b0;
      peak_rate = 32'h017d7840;
      buf_size = 32'h1770;
      init_full = 32'hbb8;
      void'($urandom(32'ha911));
      do_reset();
      step();
      `CHK(pic_ready, 1'b1)
      `CHK(fullness, 64'h0)
      hw = hb;
      bbc_source_inst.send_hdr(hw, 7);
      step();
      `CHK(hdr_done, 1'b1)
      `CHK(flags, 8'h0)
      k = 3000 + $urandom % 500;
      d0 = 1 + $urandom % 2000;
      fork
         bbc_source_inst.run_chan(k);
         begin
            bbc_source_inst.send_pic(d0, 32'h0, 1'b0);
            `WAITON(decode_pulse, 3600)
            c1 = cyc;
            `CHK(t > 2994 && t < 3010, 1'b1)
            bbc_source_inst.send_pic(32'h1388, 32'h3e8, 1'b0);
         end
      join
      repeat (3) step();
      `CHK(fullness, 64'(k - d0) * `BBC_FREQ_HZ)
      `CHK(flags, 8'h0)
      `WAITON(decode_pulse, 1200)
      `CHK(cyc - c1, 1000)
      `CHK(fullness, 64'h0)
      `CHK(flags.buf_under, 1'b1)
      `CHK(flags.bkt_over, 4'h3)
      bbc_source_inst.run_chan(6100);
      repeat (3) step();
      `CHK(fullness, 64'h1770 * `BBC_FREQ_HZ)
      `CHK(flags.buf_over, 1'b1)
      `CHK(flags.buf_under, 1'b1)
      pulse_calc();
      `WAITON(calc_done, 500)
      `CHK(result.bmin, 32'(lin(peak_rate, hw[1], hw[4], hw[2], hw[5])))
      `CHK(result.fmin, 32'(lin(peak_rate, hw[1], hw[4], hw[3], hw[6])))
      `CHK(result.rmin, 32'(lin(buf_size, hw[2], hw[5], hw[1], hw[4])))
      `CHK(result.fminb, 32'(lin(buf_size, hw[2], hw[5], hw[3], hw[6])))
      `CHK(result.delay, 32'(64'h0bb8 * `BBC_FREQ_HZ / peak_rate))
      `CHK(result.decodable, 1'b1)
      `CHK(result.guaranteed, 1'b1)
      // below the lowest rate and above the largest size: bmin and rmin extrapolated, fmin and fminb held
      peak_rate = 32'h00989680;
      buf_size = 32'h20d0;
      step();
      pulse_calc();
      `WAITON(calc_done, 500)
      `CHK(result.bmin, 32'(hw[2] + 64'(hw[1] - peak_rate) * 32'h3e8 / `BBC_FREQ_HZ))
      `CHK(result.fmin, hw[3])
      `CHK(result.rmin, 32'(hw[1] - 64'(buf_size - hw[2]) * `BBC_FREQ_HZ / 32'h3e8))
      `CHK(result.fminb, hw[3])
      `CHK(result.delay, 32'(64'(hw[3]) * `BBC_FREQ_HZ / peak_rate))
      `CHK(result.decodable, 1'b0)
      // B pictures: an anchor decodes one anchor gap early, a B picture on time
      do_reset();
      has_b = 1'b1;
      peak_rate = 32'h017d7840;
      first_gap = 32'hc8 + $urandom % 32'h12c;
      fork
         bbc_source_inst.run_chan(3200);
         begin
            bbc_source_inst.send_pic(32'h10, 32'h1000, 1'b0);
            `WAITON(decode_pulse, 3600)
            c1 = cyc;
            bbc_source_inst.send_pic(32'h10, 32'h1190, 1'b0);
            `WAITON(decode_pulse, 600)
            `CHK(cyc - c1, first_gap)
            c1 = cyc;
            bbc_source_inst.send_pic(32'h10, 32'h1064, 1'b1);
            `WAITON(decode_pulse, 600)
            `CHK(cyc - c1, 32'h64)
         end
      join
      // broken orderings, then an empty header; calculation must stay refused
      for (int i = 0; i < 4; i++) begin
         do_reset();
         hw = hb;
         r = $urandom % 16;
         if (i == 0) hw[4] = hw[1] - r;
         else if (i < 3) hw[4 + i] = hw[1 + i] + r;
         else hw[0] = 32'h0;
         bbc_source_inst.send_hdr(hw, (i == 3) ? 1 : 7);
         step();
         `CHK(hdr_done, 1'b1)
         `CHK(flags.hdr_order, 1'(i < 3))
         `CHK(flags.hdr_count, 1'(i == 3))
         pulse_calc();
         seen = 1'b0;
         repeat (400) begin
            step();
            seen = seen | calc_done;
         end
         `CHK(seen, 1'b0)
      end
      test_done();
   end
endmodule
`default_nettype wire
